// File: core/timer_map.vh
// register offsets, field positions, reset values and mode codes of the timer bank
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH

// register indices of timer 0; byte address on the bus is four times the index
`define OFS_COUNT_HIGH 12'hf00
`define OFS_COUNT_LOW 12'hf01
`define OFS_RELOAD_HIGH 12'hf02
`define OFS_RELOAD_LOW 12'hf03
`define OFS_DUTY_MATCH_HIGH 12'hf04
`define OFS_DUTY_MATCH_LOW 12'hf05
`define OFS_TIMER_CONTROL_FIRST 12'hf06
`define OFS_TIMER_CONTROL_SECOND 12'hf07

// index bits [11:5] that select the whole bank, stride of 8 indices per timer
`define BANK_SEL 7'h78
`define CH_LSB 3
`define CH_MSB 4

// second control register fields
`define TIMER_RUN_ENABLE 7
`define OUTPUT_POLARITY 6
`define PRES_MSB 5
`define PRES_LSB 3
`define MODE_MSB 2
`define MODE_LSB 0
// first control register cascade bit
`define CASCADE_SEL 4

// operating modes
`define MODE_ONE_SHOT 3'h0
`define MODE_CONTINUOUS 3'h1
`define MODE_COUNTER 3'h2
`define MODE_PWM 3'h3
`define MODE_CAPTURE 3'h4
`define MODE_COMPARE 3'h5
`define MODE_GATED 3'h6
`define MODE_CAPTURE_COMPARE 3'h7

// reset values and the count loaded at each reload
`define RST_COUNT 16'h0001
`define RST_RELOAD 16'hffff
`define RST_DUTY 16'h0000
`define RST_CONTROL 8'h00
`define RELOAD_START 16'h0001

`endif

// File: core/timer_prescale.v
// power-of-two prescaler giving a one-cycle count tick
`timescale 1ns/1ps
module timer_prescale (
	// clock and reset
	input wire clk_sys,
	input wire rst_b,
	// control
	input wire run,
	input wire [2:0] pres,
	// tick out
	output wire tick
);
	reg [6:0] div_r;
	wire [6:0] mask;

	assign mask = (7'h01 << pres) - 7'h01;
	assign tick = run & (&(div_r | ~mask));

	// cleared while stopped so each restart divides from a clean phase
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			div_r <= 7'h00;
		end else if (!run) begin
			div_r <= 7'h00;
		end else begin
			div_r <= div_r + 7'h01;
		end
	end
endmodule

// File: core/timer_edge.v
// edge detector for a timer input already synchronous to the system clock
`timescale 1ns/1ps
module timer_edge (
	// clock and reset
	input wire clk_sys,
	input wire rst_b,
	// signal in
	input wire sig,
	// edges out
	output wire rise,
	output wire fall
);
	reg prev_r;

	assign rise = sig & ~prev_r;
	assign fall = ~sig & prev_r;

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= sig;
		end
	end
endmodule

// File: core/timer_bank.v
// bank of four 16-bit timers with byte-wide registers behind an APB slave
`timescale 1ns/1ps
`include "timer_map.vh"

// Notes on behaviour
// - count may be read while running; reads never disturb counting
// - enabled high-byte read snapshots low byte; next low read returns snapshot
// - disabled low-byte read returns the live counter byte
// - timer output generally toggles at each reload
// - count byte written while running loads at next edge, counting continues
// - reload high write goes to a holding register only
// - reload low write commits held high byte and low byte together
// - reload value is maximum count; reaching it reloads counter to one
// - in compare mode the reload value is the compare value
// - duty match value is compared continuously with the count
// - a duty match changes the pwm output
// - output polarity bit selects the pwm output levels
// - capture modes store the captured count in the duty match registers
// - timer counts only while the run enable bit is one
// - pwm polarity zero: low disabled, high on match, low on reload
module timer_bank (
	// clock and reset
	input wire clk_sys,
	input wire rst_b,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// timer pins
	input wire [3:0] timer_in,
	output wire [3:0] timer_out
);
	// address decode
	wire [11:0] idx;
	wire [1:0] ch;
	wire [11:0] local_ofs;
	wire hit;
	wire setup;
	wire access_done;
	wire wr_go;
	wire rd_high_go;
	wire aligned;
	wire in_bank;
	wire [7:0] wr_byte;
	// one select per register slot, shared by all four timers
	wire sel_cnt_hi;
	wire sel_cnt_lo;
	wire sel_rld_hi;
	wire sel_rld_lo;
	wire sel_duty_hi;
	wire sel_duty_lo;
	wire sel_ctl0;
	wire sel_ctl1;

	// per-channel state exported for the read mux
	wire [63:0] count_w;
	wire [63:0] reload_w;
	wire [63:0] duty_w;
	wire [31:0] lhold_w;
	wire [31:0] ctl0_w;
	wire [31:0] ctl1_w;

	reg [7:0] rd_byte;
	reg [15:0] cnt_sel;
	reg [15:0] rld_sel;
	reg [15:0] duty_sel;
	reg [7:0] lhold_sel;
	reg [7:0] ctl0_sel;
	reg [7:0] ctl1_sel;

	assign idx = paddr[13:2];
	assign ch = idx[`CH_MSB:`CH_LSB];
	assign local_ofs = {idx[11:5], 2'b00, idx[2:0]};
	// bytes sit in word lanes; the upper address bits lie outside the bank
	assign aligned = (paddr[1:0] == 2'b00) && (paddr[15:14] == 2'b00);
	assign in_bank = (idx[11:5] == `BANK_SEL);
	assign hit = in_bank & aligned;
	assign setup = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign wr_go = access_done & pwrite & hit & pstrb[0];
	assign wr_byte = pwdata[7:0];
	assign sel_cnt_hi = (local_ofs == `OFS_COUNT_HIGH);
	assign sel_cnt_lo = (local_ofs == `OFS_COUNT_LOW);
	assign sel_rld_hi = (local_ofs == `OFS_RELOAD_HIGH);
	assign sel_rld_lo = (local_ofs == `OFS_RELOAD_LOW);
	assign sel_duty_hi = (local_ofs == `OFS_DUTY_MATCH_HIGH);
	assign sel_duty_lo = (local_ofs == `OFS_DUTY_MATCH_LOW);
	assign sel_ctl0 = (local_ofs == `OFS_TIMER_CONTROL_FIRST);
	assign sel_ctl1 = (local_ofs == `OFS_TIMER_CONTROL_SECOND);

	// snapshot taken at the same edge that latches the read data, so high and hold agree
	assign rd_high_go = setup & ~pwrite & hit & sel_cnt_hi;

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : chan
			reg [15:0] count_r;
			reg [15:0] reload_r;
			reg [7:0] rhold_r;
			reg [15:0] duty_r;
			reg [7:0] lhold_r;
			reg [7:0] ctl0_r;
			reg [7:0] ctl1_r;
			reg out_r;
			reg started_r;
			reg [15:0] count_nxt;

			wire timer_run_enable;
			wire output_polarity;
			wire [2:0] mode;
			wire in_sel;
			wire tick;
			wire rise;
			wire fall;
			wire in_edge;
			wire step;
			wire at_max;
			wire reload_ev;
			wire cmp_ev;
			wire cap_ev;
			wire duty_match;
			wire wr_ch;
			wire wr_cnt_hi;
			wire wr_cnt_lo;
			wire wr_rld_hi;
			wire wr_rld_lo;
			wire wr_duty_hi;
			wire wr_duty_lo;
			wire wr_ctl0;
			wire wr_ctl1;
			wire snap;
			wire casc_src;

			assign timer_run_enable = ctl1_r[`TIMER_RUN_ENABLE];
			assign output_polarity = ctl1_r[`OUTPUT_POLARITY];
			assign mode = ctl1_r[`MODE_MSB:`MODE_LSB];
			// previous timer's registered output; timer 0 follows timer 3
			assign casc_src = timer_out[(i + 3) % 4];
			// cascade takes the previous timer's output instead of the pin
			assign in_sel = ctl0_r[`CASCADE_SEL] ? casc_src : timer_in[i];
			assign wr_ch = wr_go & (ch == i);
			assign wr_cnt_hi = wr_ch & sel_cnt_hi;
			assign wr_cnt_lo = wr_ch & sel_cnt_lo;
			assign wr_rld_hi = wr_ch & sel_rld_hi;
			assign wr_rld_lo = wr_ch & sel_rld_lo;
			assign wr_duty_hi = wr_ch & sel_duty_hi;
			assign wr_duty_lo = wr_ch & sel_duty_lo;
			assign wr_ctl0 = wr_ch & sel_ctl0;
			assign wr_ctl1 = wr_ch & sel_ctl1;
			// a snapshot only while running; a stopped counter is read live
			assign snap = rd_high_go & (ch == i) & timer_run_enable;

			timer_prescale u_pres (
				.clk_sys(clk_sys),
				.rst_b(rst_b),
				.run(timer_run_enable),
				.pres(ctl1_r[`PRES_MSB:`PRES_LSB]),
				.tick(tick)
			);

			timer_edge u_edge (
				.clk_sys(clk_sys),
				.rst_b(rst_b),
				.sig(in_sel),
				.rise(rise),
				.fall(fall)
			);

			assign in_edge = output_polarity ? fall : rise;
			assign step = timer_run_enable & ((mode == `MODE_COUNTER) ? in_edge :
				(mode == `MODE_GATED) ? (tick & (in_sel ^ output_polarity)) :
				(mode == `MODE_CAPTURE_COMPARE) ? (tick & started_r) : tick);
			assign at_max = (count_r == reload_r);
			assign reload_ev = step & at_max & (mode != `MODE_COMPARE);
			assign cmp_ev = step & at_max & (mode == `MODE_COMPARE);
			assign cap_ev = timer_run_enable & in_edge &
				((mode == `MODE_CAPTURE) | ((mode == `MODE_CAPTURE_COMPARE) & started_r));
			assign duty_match = timer_run_enable & (mode == `MODE_PWM) & (count_r == duty_r);

			always @* begin
				count_nxt = count_r;
				if (cap_ev && (mode == `MODE_CAPTURE_COMPARE)) begin
					count_nxt = `RELOAD_START;
				end else if (reload_ev) begin
					count_nxt = `RELOAD_START;
				end else if (step) begin
					count_nxt = count_r + 16'h0001; // compare mode rolls over naturally
				end
				// a running counter takes the written byte and counts on from it
				if (wr_cnt_hi) begin
					count_nxt[15:8] = wr_byte;
				end
				if (wr_cnt_lo) begin
					count_nxt[7:0] = wr_byte;
				end
			end

			always @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					count_r <= `RST_COUNT;
					reload_r <= `RST_RELOAD;
					rhold_r <= 8'h00;
					duty_r <= `RST_DUTY;
					lhold_r <= 8'h00;
					ctl0_r <= `RST_CONTROL;
					ctl1_r <= `RST_CONTROL;
					out_r <= 1'b0;
					started_r <= 1'b0;
				end else begin
					count_r <= count_nxt;
					if (snap) begin
						lhold_r <= count_r[7:0];
					end
					if (wr_rld_hi) begin
						rhold_r <= wr_byte;
					end
					if (wr_rld_lo) begin
						reload_r <= {rhold_r, wr_byte};
					end
					// hardware capture wins over a software write in the same cycle
					if (cap_ev) begin
						duty_r <= count_r;
					end else begin
						if (wr_duty_hi) begin
							duty_r[15:8] <= wr_byte;
						end
						if (wr_duty_lo) begin
							duty_r[7:0] <= wr_byte;
						end
					end
					if (wr_ctl0) begin
						ctl0_r <= wr_byte;
					end
					if (wr_ctl1) begin
						ctl1_r <= wr_byte;
					end else if (reload_ev && (mode == `MODE_ONE_SHOT)) begin
						ctl1_r[`TIMER_RUN_ENABLE] <= 1'b0;
					end
					// capture/compare only starts counting on its first active edge
					if (!timer_run_enable) begin
						started_r <= 1'b0;
					end else if ((mode == `MODE_CAPTURE_COMPARE) && in_edge) begin
						started_r <= 1'b1;
					end
					if (!timer_run_enable) begin
						out_r <= output_polarity;
					end else if (mode == `MODE_PWM) begin
						if (reload_ev) begin
							out_r <= output_polarity;
						end else if (duty_match) begin
							out_r <= ~output_polarity;
						end
					end else if (reload_ev || cmp_ev) begin
						out_r <= ~out_r;
					end
				end
			end

			assign timer_out[i] = out_r;
			assign count_w[16 * i +: 16] = count_r;
			assign reload_w[16 * i +: 16] = reload_r;
			assign duty_w[16 * i +: 16] = duty_r;
			assign lhold_w[8 * i +: 8] = lhold_r;
			assign ctl0_w[8 * i +: 8] = ctl0_r;
			assign ctl1_w[8 * i +: 8] = ctl1_r;
		end
	endgenerate

	// read mux; reads change no counting state
	always @* begin
		cnt_sel = count_w[16 * ch +: 16];
		rld_sel = reload_w[16 * ch +: 16];
		duty_sel = duty_w[16 * ch +: 16];
		lhold_sel = lhold_w[8 * ch +: 8];
		ctl0_sel = ctl0_w[8 * ch +: 8];
		ctl1_sel = ctl1_w[8 * ch +: 8];
		rd_byte = 8'h00;
		if (hit) begin
			case (local_ofs)
				`OFS_COUNT_HIGH: begin
					rd_byte = cnt_sel[15:8];
				end
				`OFS_COUNT_LOW: begin
					rd_byte = ctl1_sel[`TIMER_RUN_ENABLE] ? lhold_sel : cnt_sel[7:0];
				end
				`OFS_RELOAD_HIGH: begin
					rd_byte = rld_sel[15:8];
				end
				`OFS_RELOAD_LOW: begin
					rd_byte = rld_sel[7:0];
				end
				`OFS_DUTY_MATCH_HIGH: begin
					rd_byte = duty_sel[15:8];
				end
				`OFS_DUTY_MATCH_LOW: begin
					rd_byte = duty_sel[7:0];
				end
				`OFS_TIMER_CONTROL_FIRST: begin
					rd_byte = ctl0_sel;
				end
				`OFS_TIMER_CONTROL_SECOND: begin
					rd_byte = ctl1_sel;
				end
				default: begin
					rd_byte = 8'h00;
				end
			endcase
		end
	end

	// one wait-free access phase; data, ready and error all registered in setup
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
				pslverr <= ~hit;
			end else if (access_done) begin
				pslverr <= 1'b0;
			end
		end
	end
endmodule

// File: tb/timer_bank_sva.sv
// assertion checker for the timer bank register bus and timer pins
`timescale 1ns/1ps
`include "timer_map.vh"
module timer_bank_sva (
	// clock and reset
	input wire clk_sys,
	input wire rst_b,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// timer pins
	input wire [3:0] timer_out
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence bank_s;
		setup_s ##0 (paddr[1:0] == 2'h0 && paddr[15:14] == 2'h0 && paddr[13:7] == `BANK_SEL);
	endsequence
	a_ready_after_setup: assert property (setup_s |=> pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_idle_quiet: assert property (!psel |=> !pready && !pslverr)
		else $error("answer without request");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_byte_wide: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_write_no_data: assert property (pready && pwrite |-> prdata == 32'h0)
		else $error("read data on write");
	a_misalign_err: assert property ((setup_s ##0 paddr[1:0] != 2'h0) |=> pslverr)
		else $error("misaligned access accepted");
	a_bank_ok: assert property (bank_s |=> pready && !pslverr)
		else $error("bank register refused");
	a_out_reset: assert property ($rose(rst_b) |-> timer_out == 4'h0)
		else $error("timer output not low after reset");
endmodule
bind timer_bank timer_bank_sva u_sva (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_out(timer_out));

// File: tb/tb_timer_bank.sv
// self-checking bench for the timer bank
`timescale 1ns/1ps
`include "timer_map.vh"
module tb_timer_bank;
	logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, seed;
	logic [3:0] timer_in, timer_out;
	logic [3:0] pstrb, strb;
	logic [7:0] mdl [0:31];
	logic [7:0] hold [0:3];
	int fail_count, tests_run;
	timer_bank u_timer_bank (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_in(timer_in), .timer_out(timer_out));
	initial begin
		clk_sys = 0;
		forever #50 clk_sys = ~clk_sys;
	end
	function automatic [31:0] xs(input [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		xs = s ^ (s << 5);
	endfunction
	function automatic [15:0] ad(input int k, input int r);
		ad = {2'b00, `OFS_COUNT_HIGH + 12'(8 * k + r), 2'b00};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input [15:0] a, input w, input [7:0] d, output [7:0] r, output e);
		@(posedge clk_sys);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= strb;
		@(posedge clk_sys);
		penable <= 1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		r = prdata[7:0];
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input int k, input int r, input [7:0] d);
		logic [7:0] q;
		logic e;
		xfer(ad(k, r), 1, d, q, e);
		// reload high waits for the low byte
		if (r == 2) hold[k] = d;
		else if (r == 3) begin
			mdl[8 * k + 2] = hold[k];
			mdl[8 * k + 3] = d;
		end else mdl[8 * k + r] = d;
	endtask
	task automatic rd(input int k, input int r, output [7:0] q);
		logic e;
		xfer(ad(k, r), 0, 8'h00, q, e);
		chk(e, 0);
	endtask
	task automatic rdm(input int k, input int r);
		logic [7:0] q;
		rd(k, r, q);
		chk(q, mdl[8 * k + r]);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		wrap_up;
	end
	initial begin
		logic [7:0] h, l, l2;
		logic e, p;
		int n;
		rst_b = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 16'h0000;
		pwdata = 32'h0;
		timer_in = 4'h0;
		pstrb = 4'hf;
		strb = 4'hf;
		for (int i = 0; i < 4; i++) hold[i] = 8'h00;
		seed = 32'h6f06;
		for (int i = 0; i < 32; i++) mdl[i] = (i % 8 == 1) ? 8'h01 : (i % 8 == 2 || i % 8 == 3) ? 8'hff : 8'h00;
		repeat (4) @(posedge clk_sys);
		rst_b <= 1;
		for (int k = 0; k < 4; k++) for (int r = 0; r < 8; r++) rdm(k, r);
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			wr(k, 4, seed[15:8]);
			wr(k, 5, seed[7:0]);
		end
		for (int k = 0; k < 4; k++) for (int r = 4; r < 6; r++) rdm(k, r);
		xfer(16'h0000, 0, 8'h00, h, e);
		chk(e, 1);
		xfer(ad(0, 0) + 16'h1, 1, 8'h55, h, e);
		chk(e, 1);
		rdm(0, 0);
		$display("test 1 done");
		wr(0, 2, 8'h00);
		rdm(0, 2);
		wr(0, 3, 8'h10);
		rdm(0, 2);
		rdm(0, 3);
		wr(0, 1, 8'h05);
		repeat (20) @(posedge clk_sys);
		rdm(0, 1);
		$display("test 2 done");
		wr(0, 7, 8'h81);
		rd(0, 0, h);
		rd(0, 1, l);
		rd(0, 1, l2);
		chk(l2, l);
		chk(h, 0);
		chk(l >= 1 && l <= 16, 1);
		n = 0;
		p = timer_out[0];
		repeat (64) begin
			@(posedge clk_sys);
			if (timer_out[0] !== p) n++;
			p = timer_out[0];
		end
		chk(n >= 3 && n <= 5, 1);
		$display("test 3 done");
		wr(0, 7, 8'h43);
		repeat (2) @(posedge clk_sys);
		chk(timer_out[0], 1);
		wr(0, 7, 8'h03);
		repeat (2) @(posedge clk_sys);
		chk(timer_out[0], 0);
		wr(0, 4, 8'h00);
		wr(0, 5, 8'h04);
		wr(0, 7, 8'h83);
		n = 0;
		repeat (64) begin
			@(posedge clk_sys);
			n += timer_out[0];
		end
		chk(n >= 40 && n <= 58, 1);
		$display("test 4 done");
		wr(0, 7, 8'h04);
		wr(0, 5, 8'h00);
		wr(0, 1, 8'h01);
		wr(0, 7, 8'h84);
		repeat (5) @(posedge clk_sys);
		timer_in <= 4'h1;
		repeat (4) @(posedge clk_sys);
		wr(0, 7, 8'h04);
		rd(0, 4, h);
		rd(0, 5, l);
		chk(h, 0);
		chk(l >= 1 && l <= 16, 1);
		$display("test 5 done");
		repeat (10) @(posedge clk_sys);
		rdm(1, 1);
		wr(1, 2, 8'h00);
		wr(1, 3, 8'h08);
		wr(1, 7, 8'h85);
		repeat (20) @(posedge clk_sys);
		chk(timer_out[1], 1);
		rd(1, 0, h);
		rd(1, 1, l);
		chk(h, 0);
		chk(l > 8, 1);
		wr(1, 0, 8'h12);
		wr(1, 1, 8'h40);
		rd(1, 0, h);
		rd(1, 1, l);
		rd(1, 0, h);
		rd(1, 1, l2);
		chk(h, 8'h12);
		chk(l >= 8'h40 && l <= 8'h48, 1);
		chk(l2, l + 8'h06);
		wr(1, 7, 8'h05);
		rd(1, 1, l);
		repeat (10) @(posedge clk_sys);
		rd(1, 1, l2);
		chk(l2, l);
		$display("test 6 done");
		wr(2, 2, 8'h00);
		wr(2, 3, 8'h04);
		wr(2, 7, 8'h80);
		repeat (10) @(posedge clk_sys);
		rd(2, 7, h);
		chk(h, 8'h00);
		rd(2, 0, h);
		rd(2, 1, l);
		chk({h, l}, 16'h0001);
		strb = 4'h0;
		xfer(ad(3, 4), 1, 8'h5a, h, e);
		strb = 4'hf;
		chk(e, 0);
		rdm(3, 4);
		wr(3, 7, 8'h82);
		repeat (5) begin
			@(posedge clk_sys);
			timer_in[3] <= 1'b1;
			@(posedge clk_sys);
			timer_in[3] <= 1'b0;
		end
		rd(3, 0, h);
		rd(3, 1, l);
		chk({h, l}, 16'h0006);
		$display("test 7 done");
		wrap_up;
	end
endmodule
